//--- hw/result_fifo.v
/*
 small synchronous fifo carrying finished conversion results.
 assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module result_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire nrst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ff;
    reg [AW:0] rd_ff;
    wire full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
    wire empty = (wr_ff == rd_ff);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ff[AW-1:0]];
    always @(posedge clk) begin
        if (!nrst) begin
            wr_ff <= {(AW+1){1'b0}};
            rd_ff <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                mem[wr_ff[AW-1:0]] <= in_data;
                wr_ff <= wr_ff + 1'b1;
            end
            if (out_ready && !empty)
                rd_ff <= rd_ff + 1'b1;
        end
    end
endmodule // result_fifo

//--- hw/serial_adc_convert_readout.v
/*
 conversion control and serial readout of a sampling converter.
 assumes pins arrive asynchronously and are synchronised here; the
 testbench resolves pin levels from the output enables.
*/
// What this block does
// - select low: bit clock pin is driven as an output.
// - select high: bit clock pin is an input supplied by the host.
// - internal mode: bit clock derived from internal conversion clock.
// - conversion timing always from internal clock, either mode.
// - data output carries latest completed result, synced to bit clock.
// - internal mode: data bit stable across both bit clock edges.
// - convert falling edge holds sample and starts conversion, ignoring chip select.
// - convert falling edges during a conversion are ignored.
// - internal mode: previous result shifted out during current conversion.
// - chip select high floats data, busy and driven bit clock.
// - busy goes low at conversion start and stays low throughout.
// - internal mode: all transmission happens while busy is low.
// - power down high puts most logic in a low-power state.
// - result sent as 12-bit two's complement word, msb first.
// - external mode: result copied to shift register just before busy rises.
`timescale 1ns/1ps
`include "adc_readout_defines.vh"
module serial_adc_convert_readout #(
    parameter WIDTH = `RESULT_BITS,
    parameter CONVERT_START_N_CYCLES = `CONVERT_START_N_CYCLES,
    parameter TAIL_CYCLES = `BUSY_TAIL_CYCLES,
    parameter FIRST_CYCLES = `FIRST_CLK_CYCLES,
    parameter HIGH_CYCLES = `BIT_HIGH_CYCLES,
    parameter PERIOD_CYCLES = `BIT_PERIOD_CYCLES
) (
    input wire clk,
    input wire nrst,
    input wire convert_start_n,
    input wire chip_select_n,
    input wire clock_source_select,
    input wire power_down_request,
    input wire serial_bit_clock_in,
    output reg serial_bit_clock_out,
    output reg serial_bit_clock_oe,
    output reg data_out,
    output reg data_oe,
    output reg busy_n_out,
    output reg busy_n_oe,
    output reg low_power,
    input wire sample_valid,
    output wire sample_ready,
    input wire [WIDTH-1:0] sample_data
);
    localparam ST_IDLE = 3'b001;
    localparam ST_CONVERT_START_N = 3'b010;
    localparam ST_TAIL = 3'b100;
    localparam [15:0] CONVERT_START_N_N = CONVERT_START_N_CYCLES;
    localparam [15:0] TAIL_N = TAIL_CYCLES;
    localparam [15:0] FIRST_N = FIRST_CYCLES;
    localparam [15:0] HIGH_N = HIGH_CYCLES;
    localparam [15:0] PER_N = PERIOD_CYCLES;
    localparam [3:0] LAST_BIT = WIDTH - 1;

    // two-flop synchronisers; first stages read by second stages only
    reg convert_start_n_s1_ff, convert_start_n_s2_ff, convert_start_n_s3_ff;
    reg cs_s1_ff, cs_s2_ff;
    reg sel_s1_ff, sel_s2_ff;
    reg pd_s1_ff, pd_s2_ff;
    reg xclk_s1_ff, xclk_s2_ff, xclk_s3_ff;

    reg [2:0] state_ff;
    reg [15:0] cnt_ff;
    reg [15:0] bit_cnt_ff;
    reg [3:0] bit_idx_ff;
    reg sending_ff;
    reg [WIDTH-1:0] shift_ff;
    reg [WIDTH-1:0] held_ff;
    reg [WIDTH-1:0] last_ff;
    reg int_clk_ff;
    reg pop_ff;

    wire fifo_valid;
    wire [WIDTH-1:0] fifo_data;

    // results from the analog core queue here; core stalls when full
    result_fifo #(.WIDTH(WIDTH), .DEPTH(8), .AW(3)) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_data),
        .out_valid(fifo_valid),
        .out_ready(pop_ff),
        .out_data(fifo_data)
    );

    always @(posedge clk) begin
        if (!nrst) begin
            convert_start_n_s1_ff <= 1'b1;
            convert_start_n_s2_ff <= 1'b1;
            convert_start_n_s3_ff <= 1'b1;
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            sel_s1_ff <= 1'b0;
            sel_s2_ff <= 1'b0;
            pd_s1_ff <= 1'b0;
            pd_s2_ff <= 1'b0;
            xclk_s1_ff <= 1'b0;
            xclk_s2_ff <= 1'b0;
            xclk_s3_ff <= 1'b0;
        end else begin
            convert_start_n_s1_ff <= convert_start_n;
            convert_start_n_s2_ff <= convert_start_n_s1_ff;
            convert_start_n_s3_ff <= convert_start_n_s2_ff;
            cs_s1_ff <= chip_select_n;
            cs_s2_ff <= cs_s1_ff;
            sel_s1_ff <= clock_source_select;
            sel_s2_ff <= sel_s1_ff;
            pd_s1_ff <= power_down_request;
            pd_s2_ff <= pd_s1_ff;
            xclk_s1_ff <= serial_bit_clock_in;
            xclk_s2_ff <= xclk_s1_ff;
            xclk_s3_ff <= xclk_s2_ff;
        end
    end

    wire convert_start_n_fall = convert_start_n_s3_ff && !convert_start_n_s2_ff;
    wire xclk_rise = !xclk_s3_ff && xclk_s2_ff;
    wire ext_mode = sel_s2_ff;
    wire pd = pd_s2_ff;
    // an empty queue does not block the start; the last result is held again
    wire start_ok = convert_start_n_fall && !pd;

    always @(posedge clk) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 16'h0000;
            bit_cnt_ff <= 16'h0000;
            bit_idx_ff <= 4'h0;
            sending_ff <= 1'b0;
            shift_ff <= `SAMPLE_RESET;
            held_ff <= `SAMPLE_RESET;
            last_ff <= `SAMPLE_RESET;
            int_clk_ff <= 1'b0;
            pop_ff <= 1'b0;
        end else begin
            pop_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    int_clk_ff <= 1'b0;
                    sending_ff <= 1'b0;
                    // edges while converting never reach here
                    if (start_ok) begin
                        state_ff <= ST_CONVERT_START_N;
                        cnt_ff <= 16'h0000;
                        bit_cnt_ff <= 16'h0000;
                        bit_idx_ff <= 4'h0;
                        // capture the sample now: the hold moment
                        held_ff <= fifo_valid ? fifo_data : last_ff;
                        pop_ff <= fifo_valid;
                        if (!ext_mode) begin
                            shift_ff <= last_ff;
                            sending_ff <= 1'b1;
                        end
                    end
                end
                ST_CONVERT_START_N: begin
                    // conversion timed only by the local clock count
                    cnt_ff <= cnt_ff + 16'h0001;
                    if (cnt_ff == CONVERT_START_N_N - 16'h0001) begin
                        state_ff <= ST_TAIL;
                        cnt_ff <= 16'h0000;
                        last_ff <= held_ff;
                        if (ext_mode)
                            shift_ff <= held_ff;
                    end
                end
                ST_TAIL: begin
                    cnt_ff <= cnt_ff + 16'h0001;
                    // a late-finishing word must not leave busy stuck low
                    if (cnt_ff >= TAIL_N - 16'h0001 && !sending_ff)
                        state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase

            // internal bit clock divided from the conversion clock
            if (sending_ff && state_ff != ST_IDLE) begin
                bit_cnt_ff <= bit_cnt_ff + 16'h0001;
                if (bit_cnt_ff == FIRST_N + HIGH_N - 16'h0001) begin
                    int_clk_ff <= 1'b0;
                end else if (bit_cnt_ff == FIRST_N - 16'h0001) begin
                    int_clk_ff <= 1'b1;
                end
                // data changes late in the low phase, 16 cycles before the rising edge
                if (bit_cnt_ff == FIRST_N + PER_N - 16'h0001 - 16'h0010) begin
                    bit_cnt_ff <= FIRST_N - 16'h0010;
                    if (bit_idx_ff == LAST_BIT) begin
                        sending_ff <= 1'b0;
                    end else begin
                        bit_idx_ff <= bit_idx_ff + 4'h1;
                        shift_ff <= {shift_ff[WIDTH-2:0], 1'b0};
                    end
                end
            end

            // external mode: host clock rising edge advances the word
            if (ext_mode && state_ff == ST_IDLE && xclk_rise)
                shift_ff <= {shift_ff[WIDTH-2:0], 1'b0};
        end
    end

    // pin drivers; chip select gates enables only
    always @(posedge clk) begin
        if (!nrst) begin
            serial_bit_clock_out <= 1'b0;
            serial_bit_clock_oe <= 1'b0;
            data_out <= 1'b0;
            data_oe <= 1'b0;
            busy_n_out <= 1'b1;
            busy_n_oe <= 1'b0;
            low_power <= 1'b0;
        end else begin
            serial_bit_clock_out <= int_clk_ff;
            serial_bit_clock_oe <= !cs_s2_ff && !ext_mode;
            data_out <= shift_ff[WIDTH-1];
            data_oe <= !cs_s2_ff;
            busy_n_out <= (state_ff == ST_IDLE) && !start_ok;
            busy_n_oe <= !cs_s2_ff;
            low_power <= pd && state_ff == ST_IDLE;
        end
    end
endmodule // serial_adc_convert_readout

//--- pkg/adc_readout_defines.vh
/*
 constants for the converter control and serial readout block.
 assumes inclusion by bare name; definitions only.
*/
`ifndef ADC_READOUT_DEFINES_VH
`define ADC_READOUT_DEFINES_VH
`define CLK_PERIOD_NS 10
`define RESULT_BITS 12
`define CONVERT_START_N_TIME_NS 15000
`define CONVERT_START_N_CYCLES (`CONVERT_START_N_TIME_NS / `CLK_PERIOD_NS)
`define BUSY_TAIL_NS 1000
`define BUSY_TAIL_CYCLES (`BUSY_TAIL_NS / `CLK_PERIOD_NS)
`define FIRST_CLK_NS 1400
`define FIRST_CLK_CYCLES (`FIRST_CLK_NS / `CLK_PERIOD_NS)
`define BIT_HIGH_NS 350
`define BIT_HIGH_CYCLES (`BIT_HIGH_NS / `CLK_PERIOD_NS)
`define BIT_PERIOD_NS 1100
`define BIT_PERIOD_CYCLES (`BIT_PERIOD_NS / `CLK_PERIOD_NS)
`define SAMPLE_RESET 12'h000
`endif

//--- verif/adc_host_model.sv
/* host model: convert strobe, external bit clock, serial capture.
   assumes the bench resolves the clock and data pin levels. */
`timescale 1ns/1ps
module adc_host_model (
    input wire clk,
    input wire bit_pin,
    input wire data_pin,
    input wire ext_mode,
    output reg convert_start_n = 1'b1,
    output reg ext_clk = 1'b0
);
    reg [11:0] rx = 12'h000;
    reg p = 1'b0;
    always @(posedge clk) begin
        p <= bit_pin;
        if (!ext_mode && bit_pin && !p) begin
            rx <= {rx[10:0], data_pin};
        end
    end
    task convert;
        begin
            @(posedge clk);
            #1 convert_start_n = 1'b0;
            repeat (10) @(posedge clk);
            #1 convert_start_n = 1'b1;
        end
    endtask
    // clock stands still outside frames; each bit taken before its rising edge
    task read_ext;
        integer n;
        begin
            for (n = 0; n < 12; n = n + 1) begin
                #40 rx = {rx[10:0], data_pin};
                ext_clk = 1'b1;
                #40 ext_clk = 1'b0;
            end
        end
    endtask
endmodule // adc_host_model

//--- verif/serial_adc_convert_readout_assertions.sv
/* pin checker for the converter readout block.
   assumes bind to its top module; synchronous active-low reset. */
`timescale 1ns/1ps
module serial_adc_convert_readout_assertions #(
    parameter CONVERT_START_N_CYCLES = 1500
) (
    input wire clk,
    input wire nrst,
    input wire convert_start_n,
    input wire chip_select_n,
    input wire clock_source_select,
    input wire power_down_request,
    input wire serial_bit_clock_out,
    input wire serial_bit_clock_oe,
    input wire data_out,
    input wire data_oe,
    input wire busy_n_out,
    input wire busy_n_oe
);
    reg [15:0] low_cnt_ff;
    // busy low length, to bound the conversion from below
    always @(posedge clk) begin
        if (!nrst || busy_n_out) begin
            low_cnt_ff <= 16'h0000;
        end else begin
            low_cnt_ff <= low_cnt_ff + 16'h0001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_start;
        busy_n_out && !power_down_request && $fell(convert_start_n);
    endsequence
    sequence s_int;
        (!chip_select_n && !clock_source_select)[*6];
    endsequence
    property p_start; s_start |-> ##[3:5] !busy_n_out; endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_cs_on; !chip_select_n[*6] |-> data_oe && busy_n_oe; endproperty
    a_cs_on: assert property (p_cs_on) else $error("not enabled");
    property p_cs_off; chip_select_n[*6] |-> !(data_oe || busy_n_oe || serial_bit_clock_oe);
    endproperty
    a_cs_off: assert property (p_cs_off) else $error("not floated");
    property p_int; s_int |-> serial_bit_clock_oe; endproperty
    a_int: assert property (p_int) else $error("clock not driven");
    property p_ext; clock_source_select[*6] |-> !serial_bit_clock_oe; endproperty
    a_ext: assert property (p_ext) else $error("clock driven");
    property p_rise; $rose(busy_n_out) |-> low_cnt_ff >= CONVERT_START_N_CYCLES; endproperty
    a_rise: assert property (p_rise) else $error("busy short");
    property p_frame; serial_bit_clock_out |-> !busy_n_out; endproperty
    a_frame: assert property (p_frame) else $error("clock outside busy");
    property p_hold; serial_bit_clock_out || $past(serial_bit_clock_out) |-> $stable(data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved");
endmodule // serial_adc_convert_readout_assertions
bind serial_adc_convert_readout serial_adc_convert_readout_assertions #(
    .CONVERT_START_N_CYCLES(CONVERT_START_N_CYCLES)) i_chk (.clk, .nrst, .convert_start_n, .chip_select_n,
    .clock_source_select, .power_down_request, .serial_bit_clock_out, .serial_bit_clock_oe,
    .data_out, .data_oe, .busy_n_out, .busy_n_oe);

//--- verif/testbench.sv
/* bench: host model, queue reference of results, shortened counts.
   assumes 100 MHz clock and the checker bound to the block. */
`timescale 1ns/1ps
module testbench;
    reg clk = 1'b0, nrst = 1'b0, chip_select_n = 1'b0, clock_source_select = 1'b0;
    reg power_down_request = 1'b0, sample_valid = 1'b0;
    reg [11:0] sample_data = 12'h000, prev = 12'h000;
    wire convert_start_n, ext_clk, serial_bit_clock_out, serial_bit_clock_oe, data_out;
    wire data_oe, busy_n_out, busy_n_oe, low_power, sample_ready, bit_pin, data_pin;
    integer miscompares = 0, checked = 0, cycles = 0, i, k;
    reg [11:0] q[$];
    assign bit_pin = serial_bit_clock_oe ? serial_bit_clock_out : ext_clk;
    assign data_pin = data_oe ? data_out : ~data_out;
    serial_adc_convert_readout #(.CONVERT_START_N_CYCLES(400), .TAIL_CYCLES(10), .FIRST_CYCLES(20),
        .HIGH_CYCLES(5), .PERIOD_CYCLES(24)) i_serial_adc_convert_readout (.clk, .nrst,
        .convert_start_n, .chip_select_n, .clock_source_select, .power_down_request,
        .serial_bit_clock_in(bit_pin), .serial_bit_clock_out, .serial_bit_clock_oe, .data_out,
        .data_oe, .busy_n_out, .busy_n_oe, .low_power, .sample_valid, .sample_ready,
        .sample_data);
    adc_host_model i_adc_host_model (.clk, .bit_pin, .data_pin,
        .ext_mode(clock_source_select), .convert_start_n, .ext_clk);
    initial begin
        forever #5 clk = ~clk;
    end
    task results;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            results;
        end
    end
    task chk(input string name, input [11:0] exp, input [11:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wait_busy(input v);
        begin
            k = 0;
            while (busy_n_out !== v && k < 3000) begin
                @(posedge clk);
                k = k + 1;
            end
            #1 chk("busy_n_out", {11'h000, v}, {11'h000, busy_n_out});
        end
    endtask
    // one conversion; an empty queue repeats the last result
    task run(input ext, input cs_hi, input dbl);
        begin
            chip_select_n = cs_hi;
            clock_source_select = ext;
            i_adc_host_model.convert;
            wait_busy(1'b0);
            if (dbl) begin
                repeat (50) @(posedge clk);
                i_adc_host_model.convert;
            end
            wait_busy(1'b1);
            if (!ext && !cs_hi) chk("internal word", prev, i_adc_host_model.rx);
            if (q.size() > 0) prev = q.pop_front();
            if (ext) begin
                i_adc_host_model.read_ext;
                chk("external word", prev, i_adc_host_model.rx);
            end
            repeat (20) @(posedge clk);
            #1 $display("conversion test done");
        end
    endtask
    initial begin
        k = $urandom(97);
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (5) @(posedge clk);
        #1 chk("idle busy", 12'h001, {11'h000, busy_n_out});
        sample_valid = 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            k = $urandom;
            sample_data = k[11:0];
            chk("fifo ready", 12'h001, {11'h000, sample_ready});
            q.push_back(sample_data);
            @(posedge clk);
            #1;
        end
        chk("fifo full", 12'h000, {11'h000, sample_ready});
        sample_valid = 1'b0;
        $display("fifo fill test done");
        for (i = 0; i < 4; i = i + 1) run(1'b0, i == 2, i == 1);
        for (i = 0; i < 5; i = i + 1) run(1'b1, 1'b0, 1'b0);
        power_down_request = 1'b1;
        repeat (10) @(posedge clk);
        #1 chk("low power", 12'h001, {11'h000, low_power});
        i_adc_host_model.convert;
        repeat (20) @(posedge clk);
        #1 chk("refused", 12'h001, {11'h000, busy_n_out});
        i_adc_host_model.convert_start_n = 1'b0;
        repeat (5) @(posedge clk);
        #1 power_down_request = 1'b0;
        repeat (10) @(posedge clk);
        #1 i_adc_host_model.convert_start_n = 1'b1;
        $display("power down test done");
        run(1'b0, 1'b0, 1'b0);
        results;
    end
endmodule // testbench
